// ===== verilog/ssc_pkg.sv
// ssc_pkg: constants and types shared by both ends of the burst sram link.
// assumes nothing: pure definitions, imported by every design file.
package ssc_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   // ------------------------------------------------------------
   // operation codes held by the device
   // ------------------------------------------------------------
   localparam logic [1:0] OP_DES = 2'h0;
   localparam logic [1:0] OP_RD = 2'h1;
   localparam logic [1:0] OP_WR = 2'h2;
   // pin filter order {sleep, flow_n, order_n, oe_n} and its reset
   localparam logic [3:0] PIN_RST = 4'h5;
   // ------------------------------------------------------------
   // controller register map (byte offsets on apb)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_MODE = 8'h0C;
   localparam logic [7:0] REG_RDAT = 8'h10;
   localparam logic [7:0] REG_WDAT = 8'h20;
   localparam int CTRL_START = 0;
   localparam int CTRL_WR = 1;
   localparam int CTRL_BURST = 2;
   localparam int CTRL_LANE = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int MODE_FLOW = 0;
   localparam int MODE_ILV = 1;
   localparam int MODE_SLEEP = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] MODE_RST = 3'h0;
   // ------------------------------------------------------------
   // controller types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_ISSUE = 3'b010,
      HS_DRAIN = 3'b100
   } ssc_hstate_e;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] idx;
   } ssc_beat_s;
endpackage : ssc_pkg

// ===== verilog/ssc_if.sv
// ssc_if: the synchronous sram bus between controller and device.
// assumes both ends share one clock; resolves the shared data bus here.
`timescale 1ns/100ps
interface ssc_if import ssc_pkg::*; #(parameter int AW = ADDR_W);
   logic clk_en_n;
   logic chip_sel_lo1;
   logic chip_sel_hi2;
   logic chip_sel_lo3;
   logic advance_load;
   logic write_n;
   logic [LANES-1:0] byte_lane_n;
   logic [AW-1:0] addr;
   logic out_en_n;
   logic sleep_request;
   logic flow_thru_sel_n;
   logic linear_order_n;
   logic [DATA_W-1:0] dev_dq;
   logic dev_oe;
   logic [DATA_W-1:0] host_dq;
   logic host_oe;
   logic [DATA_W-1:0] dq_bus;
   // undriven bus reads as zero, no float level modelled
   assign dq_bus = dev_oe ? dev_dq : (host_oe ? host_dq : '0);
   modport dev (
      input clk_en_n, chip_sel_lo1, chip_sel_hi2, chip_sel_lo3,
      input advance_load, write_n, byte_lane_n, addr, out_en_n,
      input sleep_request, flow_thru_sel_n, linear_order_n, dq_bus,
      output dev_dq, dev_oe
   );
   modport host (
      output clk_en_n, chip_sel_lo1, chip_sel_hi2, chip_sel_lo3,
      output advance_load, write_n, byte_lane_n, addr, out_en_n,
      output sleep_request, flow_thru_sel_n, linear_order_n,
      output host_dq, host_oe,
      input dq_bus
   );
endinterface : ssc_if

// ===== verilog/ssc_sram_dev.sv
// ssc_sram_dev: synchronous burst sram, pipelined or flow-through.
// assumes the controller runs on sys_clk; straps, sleep and output
// enable are treated as asynchronous pins.
`timescale 1ns/100ps
module ssc_sram_dev import ssc_pkg::*; #(
   parameter int AW = ADDR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // memory bus
   ssc_if.dev bus,
   // status
   output logic sleeping,
   output logic flow_mode
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (AW < 3 || AW > 20) begin : g_chk
      $error("ssc_sram_dev: AW must be 3..20");
   end
   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:(1<<AW)-1];
   logic [3:0] s1_ff, s2_ff, s3_ff, flt_ff;
   logic [3:0] nxt_s1_ff, nxt_s2_ff, nxt_s3_ff, nxt_flt_ff;
   logic fm_ff, nxt_fm_ff;
   logic [1:0] op_ff, nxt_op_ff;
   logic [AW-1:0] base_ff, nxt_base_ff;
   logic [1:0] cnt_ff, nxt_cnt_ff;
   logic [1:0] st1_op_ff, nxt_st1_op_ff;
   logic [AW-1:0] st1_a_ff, nxt_st1_a_ff;
   logic [LANES-1:0] st1_ln_ff, nxt_st1_ln_ff;
   logic [DATA_W-1:0] rd1_ff, nxt_rd1_ff;
   logic [1:0] st2_op_ff, nxt_st2_op_ff;
   logic [AW-1:0] st2_a_ff, nxt_st2_a_ff;
   logic [LANES-1:0] st2_ln_ff, nxt_st2_ln_ff;
   logic [DATA_W-1:0] dqo_ff, nxt_dqo_ff;
   logic oe_ff, nxt_oe_ff;
   // combinational helpers
   logic sel;
   logic slp;
   logic flow;
   logic ilv;
   logic oe_pin_n;
   logic run;
   logic [1:0] op;
   logic [AW-1:0] base;
   logic [1:0] cnt;
   logic [1:0] lo;
   logic [AW-1:0] ea;
   logic [LANES-1:0] ln;
   logic [DATA_W-1:0] memv;
   logic [1:0] wop;
   logic [AW-1:0] wa;
   logic [LANES-1:0] wln;
   // ------------------------------------------------------------
   // asynchronous pin filter
   // ------------------------------------------------------------
   // a change counts once stages two and three agree
   always_comb begin
      nxt_s1_ff = {bus.sleep_request, bus.flow_thru_sel_n,
                   bus.linear_order_n, bus.out_en_n};
      nxt_s2_ff = s1_ff;
      nxt_s3_ff = s2_ff;
      nxt_flt_ff = (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
      // mode flag kept in its own flop so the pin is a plain register
      nxt_fm_ff = ~nxt_flt_ff[2];
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_ff <= PIN_RST;
         s2_ff <= PIN_RST;
         s3_ff <= PIN_RST;
         flt_ff <= PIN_RST;
         fm_ff <= ~PIN_RST[2];
      end else begin
         s1_ff <= nxt_s1_ff;
         s2_ff <= nxt_s2_ff;
         s3_ff <= nxt_s3_ff;
         flt_ff <= nxt_flt_ff;
         fm_ff <= nxt_fm_ff;
      end
   end
   // ------------------------------------------------------------
   // command decode, burst counter and data pipeline
   // ------------------------------------------------------------
   always_comb begin
      slp = flt_ff[3];
      flow = ~flt_ff[2];
      ilv = flt_ff[1];
      oe_pin_n = flt_ff[0];
      run = ~bus.clk_en_n & ~slp;
      sel = ~bus.chip_sel_lo1 & bus.chip_sel_hi2
            & ~bus.chip_sel_lo3;
      // continue: keep op and base, step the counter
      op = op_ff;
      base = base_ff;
      cnt = cnt_ff + 2'h1;
      if (!bus.advance_load) begin
         base = bus.addr;
         cnt = 2'h0;
         if (!sel) begin
            op = OP_DES;
         end else if (bus.write_n) begin
            op = OP_RD;
         end else begin
            op = OP_WR;
         end
      end
      if (ilv) begin
         lo = base[1:0] ^ cnt;
      end else begin
         lo = base[1:0] + cnt;
      end
      ea = {base[AW-1:2], lo};
      // abort when no lane is low
      ln = (op == OP_WR) ? ~bus.byte_lane_n : '0;
      memv = mem[ea];
      nxt_op_ff = op_ff;
      nxt_base_ff = base_ff;
      nxt_cnt_ff = cnt_ff;
      nxt_st1_op_ff = st1_op_ff;
      nxt_st1_a_ff = st1_a_ff;
      nxt_st1_ln_ff = st1_ln_ff;
      nxt_rd1_ff = rd1_ff;
      nxt_st2_op_ff = st2_op_ff;
      nxt_st2_a_ff = st2_a_ff;
      nxt_st2_ln_ff = st2_ln_ff;
      nxt_dqo_ff = dqo_ff;
      // a stall holds the driver as it stands
      nxt_oe_ff = oe_ff;
      if (slp) begin
         nxt_oe_ff = 1'b0;
      end else if (run) begin
         nxt_op_ff = op;
         nxt_base_ff = base;
         nxt_cnt_ff = cnt;
         nxt_st1_op_ff = op;
         nxt_st1_a_ff = ea;
         nxt_st1_ln_ff = ln;
         nxt_rd1_ff = memv;
         nxt_st2_op_ff = st1_op_ff;
         nxt_st2_a_ff = st1_a_ff;
         nxt_st2_ln_ff = st1_ln_ff;
         if (flow) begin
            nxt_dqo_ff = memv;
            nxt_oe_ff = (op == OP_RD) & ~oe_pin_n;
         end else begin
            nxt_dqo_ff = rd1_ff;
            nxt_oe_ff = (st1_op_ff == OP_RD) & ~oe_pin_n;
         end
      end
      // write takes its data in the same cycle its read twin would drive
      wop = flow ? st1_op_ff : st2_op_ff;
      wa = flow ? st1_a_ff : st2_a_ff;
      wln = flow ? st1_ln_ff : st2_ln_ff;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_ff <= OP_DES;
         base_ff <= '0;
         cnt_ff <= 2'h0;
         st1_op_ff <= OP_DES;
         st1_a_ff <= '0;
         st1_ln_ff <= '0;
         rd1_ff <= '0;
         st2_op_ff <= OP_DES;
         st2_a_ff <= '0;
         st2_ln_ff <= '0;
         dqo_ff <= '0;
         oe_ff <= 1'b0;
      end else begin
         op_ff <= nxt_op_ff;
         base_ff <= nxt_base_ff;
         cnt_ff <= nxt_cnt_ff;
         st1_op_ff <= nxt_st1_op_ff;
         st1_a_ff <= nxt_st1_a_ff;
         st1_ln_ff <= nxt_st1_ln_ff;
         rd1_ff <= nxt_rd1_ff;
         st2_op_ff <= nxt_st2_op_ff;
         st2_a_ff <= nxt_st2_a_ff;
         st2_ln_ff <= nxt_st2_ln_ff;
         dqo_ff <= nxt_dqo_ff;
         oe_ff <= nxt_oe_ff;
      end
   end
   // ------------------------------------------------------------
   // memory array
   // ------------------------------------------------------------
   // no bypass: a read of a word still in the write pipe
   // returns the old contents
   always_ff @(posedge sys_clk) begin
      if (run && wop == OP_WR) begin
         for (int i = 0; i < LANES; i++) begin
            if (wln[i]) begin
               mem[wa][i*LANE_W +: LANE_W] <=
                  bus.dq_bus[i*LANE_W +: LANE_W];
            end
         end
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign bus.dev_dq = dqo_ff;
   assign bus.dev_oe = oe_ff;
   assign sleeping = flt_ff[3];
   assign flow_mode = fm_ff;
endmodule : ssc_sram_dev

// ===== verilog/ssc_sram_host.sv
// ssc_sram_host: apb-driven controller issuing single or 4-beat bursts.
// assumes an apb master on sys_clk and the device on the same clock.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
module ssc_sram_host import ssc_pkg::*; #(
   parameter int AW = ADDR_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // memory bus
   ssc_if.host bus,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   if (AW < 3 || AW > 32) begin : g_chk
      $error("ssc_sram_host: AW must be 3..32");
   end
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ssc_hstate_e st_ff, nxt_st_ff;
   logic [7:0] ctrl_ff, nxt_ctrl_ff;
   logic [AW-1:0] addr_ff, nxt_addr_ff;
   logic [2:0] mode_ff, nxt_mode_ff;
   logic done_ff, nxt_done_ff;
   logic [31:0] rdat_ff [LANES], nxt_rdat_ff [LANES];
   logic [31:0] wdat_ff [LANES], nxt_wdat_ff [LANES];
   logic [1:0] beat_ff, nxt_beat_ff;
   logic adv_ff, nxt_adv_ff;
   logic cs_n_ff, nxt_cs_n_ff;
   logic wn_ff, nxt_wn_ff;
   logic [LANES-1:0] bl_ff, nxt_bl_ff;
   logic [AW-1:0] pa_ff, nxt_pa_ff;
   ssc_beat_s cur_ff, nxt_cur_ff, p1_ff, p2_ff;
   logic [DATA_W-1:0] dq_ff, nxt_dq_ff;
   logic dqoe_ff, nxt_dqoe_ff;
   logic pwr_ff;
   logic pwr_n_ff;
   logic flow_n_ff, nxt_flow_n_ff;
   logic [31:0] prdata_ff, nxt_prdata_ff;
   logic pready_ff;
   logic pslverr_ff, nxt_pslverr_ff;
   logic acc;
   logic hit;
   logic [1:0] ri;
   ssc_beat_s ws, cs;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st_ff = st_ff;
      nxt_ctrl_ff = ctrl_ff;
      nxt_addr_ff = addr_ff;
      nxt_mode_ff = mode_ff;
      nxt_done_ff = done_ff;
      nxt_rdat_ff = rdat_ff;
      nxt_wdat_ff = wdat_ff;
      nxt_beat_ff = beat_ff;
      nxt_adv_ff = adv_ff;
      nxt_cs_n_ff = cs_n_ff;
      nxt_wn_ff = wn_ff;
      nxt_bl_ff = bl_ff;
      nxt_pa_ff = pa_ff;
      nxt_cur_ff = cur_ff;
      nxt_prdata_ff = prdata_ff;
      nxt_pslverr_ff = pslverr_ff;
      ri = paddr[3:2];
      acc = psel & penable & pready_ff;
      // register read data prepared in the setup cycle
      hit = 1'b1;
      case (paddr[7:4])
         REG_CTRL[7:4]: begin
            case (paddr[3:0])
               REG_CTRL[3:0]: nxt_prdata_ff = {24'h0, ctrl_ff};
               REG_STAT[3:0]: nxt_prdata_ff =
                  {30'h0, done_ff, st_ff != HS_IDLE};
               REG_ADDR[3:0]: nxt_prdata_ff = 32'(addr_ff);
               REG_MODE[3:0]: nxt_prdata_ff = {29'h0, mode_ff};
               default: hit = 1'b0;
            endcase
         end
         REG_RDAT[7:4]: nxt_prdata_ff = rdat_ff[ri];
         REG_WDAT[7:4]: nxt_prdata_ff = wdat_ff[ri];
         default: hit = 1'b0;
      endcase
      if (!hit || paddr[1:0] != 2'h0) begin
         nxt_prdata_ff = 32'h0;
         hit = 1'b0;
      end
      if (psel && !penable) begin
         nxt_pslverr_ff = ~hit;
      end else begin
         nxt_prdata_ff = prdata_ff;
      end
      if (acc && pwrite && hit) begin
         case (paddr[7:4])
            REG_CTRL[7:4]: begin
               case (paddr[3:0])
                  REG_CTRL[3:0]: nxt_ctrl_ff = pwdata[7:0];
                  REG_STAT[3:0]: if (pwdata[STAT_DONE]) nxt_done_ff = 1'b0;
                  REG_ADDR[3:0]: nxt_addr_ff = pwdata[AW-1:0];
                  default: nxt_mode_ff = pwdata[2:0];
               endcase
            end
            REG_WDAT[7:4]: nxt_wdat_ff[ri] = pwdata;
            default: nxt_ctrl_ff = ctrl_ff;
         endcase
      end
      // beat sequencer
      case (st_ff)
         HS_IDLE: begin
            if (acc && pwrite && hit && paddr == REG_CTRL &&
                pwdata[CTRL_START]) begin
               nxt_st_ff = HS_ISSUE;
               nxt_adv_ff = 1'b0;
               nxt_cs_n_ff = 1'b0;
               nxt_wn_ff = ~pwdata[CTRL_WR];
               nxt_bl_ff = pwdata[CTRL_WR] ?
                  ~pwdata[CTRL_LANE +: LANES] : '1;
               nxt_pa_ff = addr_ff;
               nxt_beat_ff = 2'h0;
               nxt_cur_ff = '{~pwdata[CTRL_WR], pwdata[CTRL_WR], 2'h0};
            end
         end
         HS_ISSUE: begin
            if (beat_ff == BEAT_LAST || !ctrl_ff[CTRL_BURST]) begin
               nxt_st_ff = HS_DRAIN;
               nxt_adv_ff = 1'b0;
               nxt_cs_n_ff = 1'b1;
               nxt_cur_ff = '0;
            end else begin
               nxt_adv_ff = 1'b1;
               nxt_beat_ff = beat_ff + 2'h1;
               nxt_cur_ff.idx = beat_ff + 2'h1;
            end
         end
         HS_DRAIN: begin
            if (!p1_ff.rd && !p1_ff.wr && !p2_ff.rd && !p2_ff.wr) begin
               nxt_st_ff = HS_IDLE;
               nxt_done_ff = 1'b1;
            end
         end
         default: nxt_st_ff = HS_IDLE;
      endcase
      // write data one stage ahead of read capture, same delay
      ws = mode_ff[MODE_FLOW] ? cur_ff : p1_ff;
      cs = mode_ff[MODE_FLOW] ? p1_ff : p2_ff;
      nxt_dqoe_ff = ws.wr;
      for (int i = 0; i < LANES; i++) begin
         nxt_dq_ff[i*LANE_W +: LANE_W] = {1'b0, wdat_ff[ws.idx][i*8 +: 8]};
      end
      if (cs.rd) begin
         for (int i = 0; i < LANES; i++) begin
            nxt_rdat_ff[cs.idx][i*8 +: 8] = bus.dq_bus[i*LANE_W +: 8];
         end
      end
      nxt_flow_n_ff = ~nxt_mode_ff[MODE_FLOW];
   end
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= HS_IDLE;
         ctrl_ff <= CTRL_RST;
         addr_ff <= '0;
         mode_ff <= MODE_RST;
         done_ff <= 1'b0;
         rdat_ff <= '{default: 32'h0};
         wdat_ff <= '{default: 32'h0};
         beat_ff <= 2'h0;
         adv_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         wn_ff <= 1'b1;
         bl_ff <= '1;
         pa_ff <= '0;
         cur_ff <= '0;
         p1_ff <= '0;
         p2_ff <= '0;
         dq_ff <= '0;
         dqoe_ff <= 1'b0;
         pwr_ff <= 1'b0;
         pwr_n_ff <= 1'b1;
         flow_n_ff <= 1'b1;
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st_ff;
         ctrl_ff <= nxt_ctrl_ff;
         addr_ff <= nxt_addr_ff;
         mode_ff <= nxt_mode_ff;
         done_ff <= nxt_done_ff;
         rdat_ff <= nxt_rdat_ff;
         wdat_ff <= nxt_wdat_ff;
         beat_ff <= nxt_beat_ff;
         adv_ff <= nxt_adv_ff;
         cs_n_ff <= nxt_cs_n_ff;
         wn_ff <= nxt_wn_ff;
         bl_ff <= nxt_bl_ff;
         pa_ff <= nxt_pa_ff;
         cur_ff <= nxt_cur_ff;
         p1_ff <= cur_ff;
         p2_ff <= p1_ff;
         dq_ff <= nxt_dq_ff;
         dqoe_ff <= nxt_dqoe_ff;
         pwr_ff <= 1'b1;
         pwr_n_ff <= 1'b0;
         flow_n_ff <= nxt_flow_n_ff;
         prdata_ff <= nxt_prdata_ff;
         pready_ff <= 1'b1;
         pslverr_ff <= nxt_pslverr_ff;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign bus.clk_en_n = pwr_n_ff;
   assign bus.chip_sel_lo1 = cs_n_ff;
   assign bus.chip_sel_hi2 = pwr_ff;
   assign bus.chip_sel_lo3 = pwr_n_ff;
   assign bus.advance_load = adv_ff;
   assign bus.write_n = wn_ff;
   assign bus.byte_lane_n = bl_ff;
   assign bus.addr = pa_ff;
   assign bus.out_en_n = pwr_n_ff;
   assign bus.sleep_request = mode_ff[MODE_SLEEP];
   assign bus.flow_thru_sel_n = flow_n_ff;
   assign bus.linear_order_n = mode_ff[MODE_ILV];
   assign bus.host_dq = dq_ff;
   assign bus.host_oe = dqoe_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
endmodule : ssc_sram_host

// ===== testbench/ssc_link_monitor.sv
// ssc_link_monitor: timing checks on the sram link between both ends.
// assumes the interface pins as plain inputs, one clock, async reset.
`timescale 1ns/100ps
module ssc_link_monitor import ssc_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // command pins
   input wire logic clk_en_n,
   input wire logic chip_sel_lo1,
   input wire logic chip_sel_hi2,
   input wire logic chip_sel_lo3,
   input wire logic advance_load,
   input wire logic write_n,
   input wire logic [LANES-1:0] byte_lane_n,
   // mode pins
   input wire logic out_en_n,
   input wire logic sleep_request,
   input wire logic flow_thru_sel_n,
   // data drive enables
   input wire logic dev_oe,
   input wire logic host_oe
);
   logic [2:0] pins_ff;
   logic [2:0] nxt_pins;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic sel, load, rd, wr, des, settled, ok, piped, flow;
   // device filters mode pins, so only judge once they sat still
   always_comb begin
      nxt_pins = {sleep_request, flow_thru_sel_n, out_en_n};
      nxt_cnt = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
      if (nxt_pins != pins_ff) begin
         nxt_cnt = 3'h0;
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pins_ff <= 3'h0;
         cnt_ff <= 3'h0;
      end else begin
         pins_ff <= nxt_pins;
         cnt_ff <= nxt_cnt;
      end
   end
   assign sel = !chip_sel_lo1 && chip_sel_hi2 && !chip_sel_lo3;
   assign load = !clk_en_n && !advance_load;
   assign rd = load && sel && write_n;
   assign wr = load && sel && !write_n && !(&byte_lane_n);
   assign des = load && !sel;
   assign settled = cnt_ff >= 3'h5;
   assign ok = settled && !sleep_request && !out_en_n;
   assign piped = ok && flow_thru_sel_n;
   assign flow = ok && !flow_thru_sel_n;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_bus_no_clash: assert property (
      !(dev_oe && host_oe)) else $error("data bus driven by both ends");
   a_pipe_rd_lat: assert property (
      piped && rd |-> ##2 dev_oe) else $error("pipelined read data late");
   a_flow_rd_lat: assert property (
      flow && rd |-> ##1 dev_oe) else $error("flow read data late");
   a_pipe_wr_slot: assert property (
      piped && wr |-> ##2 (host_oe && !dev_oe))
      else $error("pipelined write slot wrong");
   a_flow_wr_slot: assert property (
      flow && wr |-> ##1 (host_oe && !dev_oe))
      else $error("flow write slot wrong");
   a_desel_float: assert property (
      piped && des |-> ##2 !dev_oe) else $error("deselect drove bus");
   a_sleep_float: assert property (
      sleep_request && settled |-> !dev_oe) else $error("bus driven asleep");
   a_reset_float: assert property (
      $rose(arst_n) |-> !dev_oe) else $error("bus driven after reset");
endmodule : ssc_link_monitor

// ===== testbench/sync_burst_sram_control_tb.sv
// sync_burst_sram_control_tb: apb-driven controller against the device.
// assumes the design files are compiled first; one 100 MHz clock.
`timescale 1ns/100ps
module sync_burst_sram_control_tb import ssc_pkg::*; ;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic sleeping, flow_mode, ilv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, seed;
   logic [31:0] mem [256];
   logic [31:0] wd [4];
   logic [33:0] exp_q [$];
   logic [33:0] e;
   int fail_count, samples_checked;
   ssc_if bus ();
   ssc_sram_dev ssc_sram_dev_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .bus(bus), .sleeping(sleeping), .flow_mode(flow_mode));
   ssc_sram_host ssc_sram_host_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .bus(bus), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   ssc_link_monitor ssc_link_monitor_inst (.sys_clk(sys_clk),
      .arst_n(arst_n), .clk_en_n(bus.clk_en_n),
      .chip_sel_lo1(bus.chip_sel_lo1), .chip_sel_hi2(bus.chip_sel_hi2),
      .chip_sel_lo3(bus.chip_sel_lo3), .advance_load(bus.advance_load),
      .write_n(bus.write_n), .byte_lane_n(bus.byte_lane_n),
      .out_en_n(bus.out_en_n), .sleep_request(bus.sleep_request),
      .flow_thru_sel_n(bus.flow_thru_sel_n), .dev_oe(bus.dev_oe),
      .host_oe(bus.host_oe));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // burst low bits: sum or xor with the beat number, wrapping in four
   function logic [7:0] ba(input logic [7:0] a, input logic [1:0] i);
      return {a[7:2], ilv ? a[1:0] ^ i : a[1:0] + i};
   endfunction : ba
   task chk(input string what, input logic [32:0] x, input logic [32:0] g);
      samples_checked++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, x, g);
      end
   endtask : chk
   // ------------------------------------------------------------
   // apb master
   // ------------------------------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [33:0] x, output logic [31:0] q);
      if (!w) exp_q.push_back(x);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no cycle count assumed; pready ends this wait, the watchdog bounds it
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0, r);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {2'h2, d}, r);
   endtask : rd
   // read results are judged here, in order of issue
   always @(posedge sys_clk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
         e = exp_q.pop_front();
         if (e[33]) chk("apb read", e[32:0], {pslverr, prdata});
      end
   end
   // ------------------------------------------------------------
   // memory operations
   // ------------------------------------------------------------
   task op(input logic w, input logic b, input logic [3:0] ln,
           input logic [7:0] a);
      int n;
      wr(REG_ADDR, {24'h0, a});
      wr(REG_CTRL, {24'h0, ln, 1'b0, b, w, 1'b1});
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0, 34'h0, r);
         n++;
      end while (r[STAT_DONE] !== 1'b1 && n < 20);
      rd(REG_STAT, 32'h2);
      wr(REG_STAT, 32'h2);
   endtask : op
   task wrop(input logic b, input logic [3:0] ln, input logic [7:0] a);
      for (int i = 0; i < 4; i++) begin
         wd[i] = rnd();
         wr(REG_WDAT + 8'(i * 4), wd[i]);
      end
      op(1'b1, b, ln, a);
      for (int i = 0; i < (b ? 4 : 1); i++)
         for (int k = 0; k < 4; k++)
            if (ln[k]) mem[ba(a, 2'(i))][8*k +: 8] = wd[i][8*k +: 8];
   endtask : wrop
   task rdop(input logic b, input logic [7:0] a);
      op(1'b0, b, 4'hF, a);
      for (int i = 0; i < (b ? 4 : 1); i++)
         rd(REG_RDAT + 8'(i * 4), mem[ba(a, 2'(i))]);
   endtask : rdop
   // device filters mode pins over a few edges, so let them settle
   task mode(input logic [31:0] d);
      wr(REG_MODE, d);
      repeat (6) @(posedge sys_clk);
      rd(REG_MODE, d);
   endtask : mode
   task summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // whole sequence needs a few hundred cycles; this is ample
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      summarize();
   end
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      arst_n = 1'b0;
      ilv = 1'b0;
      seed = 32'h15;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(REG_MODE, 32'h0);
      wrop(1'b1, 4'hF, 8'h05);
      rdop(1'b1, 8'h06);
      rdop(1'b0, 8'h04);
      wrop(1'b0, 4'h5, 8'h04);
      rdop(1'b0, 8'h04);
      wrop(1'b0, 4'h0, 8'h04);
      rdop(1'b0, 8'h04);
      apb(1'b0, 8'h40, 32'h0, {2'h3, 32'h0}, r);
      apb(1'b0, 8'h01, 32'h0, {2'h3, 32'h0}, r);
      ilv = 1'b1;
      mode(32'h2);
      wrop(1'b1, 4'hF, 8'h09);
      rdop(1'b1, 8'h0A);
      ilv = 1'b0;
      mode(32'h1);
      chk("flow_mode", 33'h1, {32'h0, flow_mode});
      wrop(1'b1, 4'hF, 8'h12);
      rdop(1'b1, 8'h13);
      rdop(1'b0, 8'h10);
      mode(32'h4);
      chk("sleeping", 33'h1, {32'h0, sleeping});
      summarize();
   end
endmodule : sync_burst_sram_control_tb
